/* rtl/dac_consts.vh */
`ifndef DAC_CONSTS_VH
`define DAC_CONSTS_VH

// ==========================================================
// Serial frame layout
`define FRAME_BITS      24
`define FRAME_PHASE_MAX 5'd23
`define FB_RW           23
`define FB_REG_HI       21
`define FB_REG_LO       19
`define FB_ADR_HI       18
`define FB_ADR_LO       16
`define FB_DATA_HI      15

// ==========================================================
// Register select and channel address codes
`define REG_FUNC        3'b000
`define REG_DATA        3'b010
`define REG_COARSE      3'b011
`define REG_FINE        3'b100
`define REG_OFFSET      3'b101
`define ADR_A           3'b000
`define ADR_B           3'b001
`define ADR_BOTH        3'b100

// ==========================================================
// Function register operations and fields
`define FN_NOP          3'b000
`define FN_CTRL         3'b001
`define FN_CLEAR        3'b100
`define FN_LOAD         3'b101
`define FN_CTRL_W       6
`define FN_OUT_OFF_BIT  0
`define FN_CTRL_RESET   6'h00

// ==========================================================
// Codes
`define ZERO_CODE       16'h0000
`define SIGN_FLIP       16'h8000
`define FINE_MASK       16'h003f

// ==========================================================
// Word store types
`define TYPE_DATA       2'd0
`define TYPE_COARSE     2'd1
`define TYPE_FINE       2'd2
`define TYPE_OFFSET     2'd3

// ==========================================================
// APB map
`define A_CTRL          8'h00
`define A_STATUS        8'h04
`define A_DAC_A         8'h08
`define A_DAC_B         8'h0c
`define A_FRAMES        8'h10
`define A_BAD           8'h14
`define A_FUNC          8'h18
`define CTRL_LINK_EN    0
`define CTRL_CLEAR      1
`define CTRL_LOAD       2
`define CTRL_RESET      1'b1

`endif

/* rtl/dac_serial_ctrl.v */
`timescale 1ns/1ns
`include "dac_consts.vh"

// Contract
// R1 - Shift serial_in MSB first into 24-bit register on clock while frame low.
// R2 - Host frame carries rw, reserved zero, select, address and 16 data bits.
// R3 - Bit 23 rw, bit 22 zero, then select, address, data 15..0.
// R4 - Reset loads zero code and clamps outputs until an update happens.
// R5 - Load strobe or clear after power-up drives outputs from held zero code.
// R6 - Coding select low means twos complement, high means offset binary.
// R7 - Falling frame select begins a frame.
// R8 - Exactly 24 falling clock edges per frame; other counts make it invalid. The code accepts any nonzero multiple of 24.
// R9 - Invalid frame leaves registers and outputs untouched.
// R10 - Rising frame select moves the word into the addressed register.
// R11 - Host keeps frame low for exact edge count, continuous or burst clock.
// R12 - Host returns frame select low to begin the next transfer.
// R13 - Past 24 pulses bits ripple to serial_out, changing on rising clock edges.
// R14 - Chain of n devices gets 24n clocks, then frame select rises.
// R15 - Rising frame select latches the word and blocks shifting until it falls.
// R16 - Host clears serial_out_off_bit before asking for readback.
// R17 - serial_out_off_bit resets cleared, so serial_out is enabled.
// R18 - rw set selects a register for reading; its data bits are ignored.
// R19 - Next frame shifts the selected register out on serial_out.
// R20 - Fine gain readback sits in data bits 5 to 0.
// R21 - Select 000 is the function register; address and data pick the function.
// R22 - Load strobe low during shifting updates the addressed output at frame end.
// R23 - Load strobe high during shifting: all outputs update on its later fall.
// R24 - Load function updates both converter registers and outputs.
// R25 - Clear fall sets 0 V in twos complement, negative full scale in binary.
// R26 - Outputs keep the cleared value after clear rises until new load.
// R27 - Clear low at power-on updates all outputs with the clear value.
// R28 - Serial clear command acts like the clear pin.
module dac_serial_ctrl (
	input  wire        CLK,           // Core clock, 100 MHz
	input  wire        RSTN,          // Synchronous reset, active low
	input  wire        CE,            // Clock enable, freezes all state when low
	input  wire        PSEL,          // APB select
	input  wire        PENABLE,       // APB access phase
	input  wire        PWRITE,        // APB direction
	input  wire [7:0]  PADDR,         // APB byte address
	input  wire [31:0] PWDATA,        // APB write data
	output reg  [31:0] PRDATA,        // APB read data
	output reg         PREADY,        // APB ready
	output reg         PSLVERR,       // APB error on unmapped address
	input  wire        SER_CLK,       // Serial clock pin
	input  wire        FRAME_SEL_N,   // Frame select pin, active low
	input  wire        SERIAL_IN,     // Serial data in
	input  wire        LOAD_STROBE_N, // Load strobe pin, active low
	input  wire        CLEAR_N,       // Clear pin, active low
	input  wire        CODING_SELECT, // Low twos complement, high offset binary
	output reg         SERIAL_OUT,    // Serial data out
	output reg         SERIAL_OUT_EN, // Serial out driven while high
	output reg  [15:0] DAC_A_CODE,    // Straight-binary ladder code, channel A
	output reg  [15:0] DAC_B_CODE,    // Straight-binary ladder code, channel B
	output reg         OUT_CLAMP      // Outputs clamped to 0 V while high
);
	// ==========================================================
	// States and helpers
	localparam [1:0] ST_IDLE  = 2'b01;
	localparam [1:0] ST_SHIFT = 2'b10;

	// Map a register select onto a store type; bit 2 flags a real register
	function [2:0] store_type;
		input [2:0] sel;
		begin
			case (sel)
				`REG_DATA:   store_type = {1'b1, `TYPE_DATA};
				`REG_COARSE: store_type = {1'b1, `TYPE_COARSE};
				`REG_FINE:   store_type = {1'b1, `TYPE_FINE};
				`REG_OFFSET: store_type = {1'b1, `TYPE_OFFSET};
				default:     store_type = 3'b000;
			endcase
		end
	endfunction

	// Channel hit mask for an address field
	function [1:0] chan_hit;
		input [2:0] adr;
		begin
			case (adr)
				`ADR_A:    chan_hit = 2'b01;
				`ADR_B:    chan_hit = 2'b10;
				`ADR_BOTH: chan_hit = 2'b11;
				default:   chan_hit = 2'b00;
			endcase
		end
	endfunction

	// ==========================================================
	// Pin synchronisers
	wire [4:0] pin_lvl;
	wire [4:0] pin_rise;
	wire [4:0] pin_fall;

	// Reset value high keeps the idle pins quiet; a low clear pin at
	// power-on shows as a fall once it reaches the second flop
	pin_sync #(
		.W       (5),
		.RST_VAL (1'b1)
	) u_sync (
		.clk   (CLK),
		.rstn  (RSTN),
		.ce    (CE),
		.pins  ({CLEAR_N, LOAD_STROBE_N, SERIAL_IN, FRAME_SEL_N, SER_CLK}),
		.level (pin_lvl),
		.rise  (pin_rise),
		.fall  (pin_fall)
	);

	// Coding strap synchronised on its own so it may reset low
	wire coding_lvl;
	pin_sync #(
		.W       (1),
		.RST_VAL (1'b0)
	) u_sync_coding (
		.clk   (CLK),
		.rstn  (RSTN),
		.ce    (CE),
		.pins  (CODING_SELECT),
		.level (coding_lvl),
		.rise  (),
		.fall  ()
	);

	wire sclk_rise = pin_rise[0];
	wire sclk_fall = pin_fall[0];
	wire fs_fall   = pin_fall[1];
	wire fs_rise   = pin_rise[1];
	wire sin_lvl   = pin_lvl[2];
	wire load_lvl  = pin_lvl[3];
	wire load_fall = pin_fall[3];
	wire clr_fall  = pin_fall[4];

	// ==========================================================
	// Registers
	reg [1:0]             state_q;
	reg [23:0]            shreg_q;
	reg [4:0]             phase_q;
	reg                   full_q;
	reg                   rd_pend_q;
	reg [5:0]             rd_sel_q;
	reg [`FN_CTRL_W-1:0]  fn_ctrl_q;
	reg [15:0]            dac_q [0:1];
	reg [15:0]            in_q [0:1];
	reg                   link_en_q;
	reg [15:0]            frames_q;
	reg [15:0]            bad_q;
	reg                   sw_clear_q;
	reg                   sw_load_q;

	// ==========================================================
	// Frame decode at frame end
	wire        frame_end = (state_q == ST_SHIFT) && fs_rise;
	wire        frame_ok  = full_q && (phase_q == 5'd0);            // R8
	wire        take      = frame_end && frame_ok;                   // R9
	wire        f_rw      = shreg_q[`FB_RW];                         // R3
	wire [2:0]  f_reg     = shreg_q[`FB_REG_HI:`FB_REG_LO];
	wire [2:0]  f_adr     = shreg_q[`FB_ADR_HI:`FB_ADR_LO];
	wire [15:0] f_data    = shreg_q[`FB_DATA_HI:0];
	wire [2:0]  f_type    = store_type(f_reg);
	wire [1:0]  f_hit     = chan_hit(f_adr);
	wire        is_func   = (f_reg == `REG_FUNC);                   // R21

	wire wr_store  = take && !f_rw && f_type[2];                     // R10
	wire [1:0] wr_ch = wr_store ? f_hit : 2'b00;
	wire fn_ctrl_w = take && !f_rw && is_func && (f_adr == `FN_CTRL);
	wire fn_clear  = take && !f_rw && is_func && (f_adr == `FN_CLEAR); // R28
	wire fn_load   = take && !f_rw && is_func && (f_adr == `FN_LOAD);  // R24

	// Load strobe held low while shifting updates the written channel
	wire [1:0] upd_one = (wr_store && (f_type[1:0] == `TYPE_DATA) && !load_lvl)
		? f_hit : 2'b00;                                               // R22
	wire upd_all = load_fall || fn_load || sw_load_q;                // R23
	wire do_clr  = clr_fall || fn_clear || sw_clear_q;               // R25

	// ==========================================================
	// Per-channel stores for input, coarse, fine and offset words
	wire [1:0]  rd_type = rd_sel_q[5:4];
	wire [15:0] st_rd [0:1];
	genvar c;
	generate
		for (c = 0; c < 2; c = c + 1) begin : g_chan
			word_store #(
				.DW (16),
				.AW (2)
			) u_store (
				.clk     (CLK),
				.rstn    (RSTN),
				.ce      (CE),
				.wr_en   (wr_ch[c]),
				.wr_idx  (f_type[1:0]),
				.wr_data (f_data),
				.rd_idx  (rd_type),
				.rd_data (st_rd[c])
			);
		end
	endgenerate

	// Readback word for the next frame; fine gain holds six bits only
	reg [15:0] rb_word;
	always @* begin
		rb_word = 16'h0000;
		if (rd_sel_q[3]) begin
			rb_word = (rd_sel_q[2] ? st_rd[1] : st_rd[0]);
			if (rd_type == `TYPE_FINE) begin
				rb_word = rb_word & `FINE_MASK;                          // R20
			end
		end else if (rd_sel_q[1]) begin
			rb_word = {{(16-`FN_CTRL_W){1'b0}}, fn_ctrl_q};
		end
	end

	// ==========================================================
	// Frame state machine, shifter and serial out
	always @(posedge CLK) begin
		if (!RSTN) begin
			state_q    <= ST_IDLE;
			shreg_q    <= 24'h000000;
			phase_q    <= 5'd0;
			full_q     <= 1'b0;
			rd_pend_q  <= 1'b0;
			SERIAL_OUT <= 1'b0;
		end else if (CE) begin
			case (state_q)
				ST_IDLE: begin
					// Shifting stays blocked until frame select falls again
					if (fs_fall && link_en_q) begin                  // R7
						state_q <= ST_SHIFT;
						phase_q <= 5'd0;
						full_q  <= 1'b0;
						if (rd_pend_q) begin                          // R19
							shreg_q    <= {8'h00, rb_word};
							SERIAL_OUT <= 1'b0;
							rd_pend_q  <= 1'b0;
						end else begin
							SERIAL_OUT <= shreg_q[23];
						end
					end
				end
				ST_SHIFT: begin
					if (fs_rise) begin
						state_q <= ST_IDLE;                           // R15
					end else if (sclk_fall) begin
						shreg_q <= {shreg_q[22:0], sin_lvl};          // R1
						if (phase_q == `FRAME_PHASE_MAX) begin
							phase_q <= 5'd0;
							full_q  <= 1'b1;
						end else begin
							phase_q <= phase_q + 5'd1;
						end
					end else if (sclk_rise) begin
						SERIAL_OUT <= shreg_q[23];                    // R13
					end
					// Read request only names the register to return
					if (take && f_rw) begin                           // R18
						rd_pend_q <= 1'b1;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Selection captured by a read request
	always @(posedge CLK) begin
		if (!RSTN) begin
			rd_sel_q <= 6'h00;
		end else if (CE && take && f_rw) begin
			rd_sel_q <= {f_type[1:0], f_type[2], f_hit[1] & ~f_hit[0],
				is_func && (f_adr == `FN_CTRL), 1'b0};
		end
	end

	// ==========================================================
	// Function control bits; serial out held off in reset, enabled from the next cycle
	always @(posedge CLK) begin
		if (!RSTN) begin
			fn_ctrl_q     <= `FN_CTRL_RESET;                         // R17
			SERIAL_OUT_EN <= 1'b0;
		end else if (CE) begin
			if (fn_ctrl_w) begin
				fn_ctrl_q <= f_data[`FN_CTRL_W-1:0];
			end
			SERIAL_OUT_EN <= ~fn_ctrl_q[`FN_OUT_OFF_BIT];
		end
	end

	// ==========================================================
	// Converter registers; clear outranks any load in the same cycle
	integer ch;
	always @(posedge CLK) begin
		if (!RSTN) begin
			dac_q[0]  <= `ZERO_CODE;                                 // R4
			dac_q[1]  <= `ZERO_CODE;
			in_q[0]   <= `ZERO_CODE;
			in_q[1]   <= `ZERO_CODE;
			OUT_CLAMP <= 1'b1;
		end else if (CE) begin
			for (ch = 0; ch < 2; ch = ch + 1) begin
				if (do_clr) begin
					dac_q[ch] <= `ZERO_CODE;                         // R27
				end else if (upd_one[ch]) begin
					dac_q[ch] <= f_data;
				end else if (upd_all) begin
					dac_q[ch] <= in_q[ch];
				end
				if (wr_ch[ch] && (f_type[1:0] == `TYPE_DATA)) begin
					in_q[ch] <= f_data;
				end
			end
			// Any update releases the clamp; the held value then stays
			if (do_clr || upd_all || (upd_one != 2'b00)) begin      // R5
				OUT_CLAMP <= 1'b0;                                    // R26
			end
		end
	end

	// Ladder wants straight binary, so twos complement flips the sign bit
	always @(posedge CLK) begin
		if (!RSTN) begin
			DAC_A_CODE <= `SIGN_FLIP;
			DAC_B_CODE <= `SIGN_FLIP;
		end else if (CE) begin
			DAC_A_CODE <= coding_lvl ? dac_q[0] : (dac_q[0] ^ `SIGN_FLIP); // R6
			DAC_B_CODE <= coding_lvl ? dac_q[1] : (dac_q[1] ^ `SIGN_FLIP);
		end
	end

	// ==========================================================
	// Frame counters for software
	always @(posedge CLK) begin
		if (!RSTN) begin
			frames_q <= 16'h0000;
			bad_q    <= 16'h0000;
		end else if (CE && frame_end) begin
			if (frame_ok) begin
				frames_q <= frames_q + 16'h0001;
			end else begin
				bad_q <= bad_q + 16'h0001;
			end
		end
	end

	// ==========================================================
	// APB slave: one wait state, then ready for one cycle
	wire apb_acc = PSEL && PENABLE;
	wire apb_hit = (PADDR == `A_CTRL) || (PADDR == `A_STATUS) ||
		(PADDR == `A_DAC_A) || (PADDR == `A_DAC_B) || (PADDR == `A_FRAMES) ||
		(PADDR == `A_BAD) || (PADDR == `A_FUNC);
	wire apb_wr  = apb_acc && PREADY && PWRITE && (PADDR == `A_CTRL);

	reg [31:0] rd_mux;
	always @* begin
		rd_mux = 32'h00000000;
		case (PADDR)
			`A_CTRL:   rd_mux = {31'h00000000, link_en_q};
			`A_STATUS: rd_mux = {27'h0000000, state_q == ST_SHIFT,
				rd_pend_q, fn_ctrl_q[`FN_OUT_OFF_BIT], coding_lvl, OUT_CLAMP};
			`A_DAC_A:  rd_mux = {16'h0000, dac_q[0]};
			`A_DAC_B:  rd_mux = {16'h0000, dac_q[1]};
			`A_FRAMES: rd_mux = {16'h0000, frames_q};
			`A_BAD:    rd_mux = {16'h0000, bad_q};
			`A_FUNC:   rd_mux = {26'h0000000, fn_ctrl_q};
			default:   rd_mux = 32'h00000000;
		endcase
	end

	// Answer and software strobes; strobes last exactly one cycle
	always @(posedge CLK) begin
		if (!RSTN) begin
			PREADY     <= 1'b0;
			PSLVERR    <= 1'b0;
			PRDATA     <= 32'h00000000;
			link_en_q  <= `CTRL_RESET;
			sw_clear_q <= 1'b0;
			sw_load_q  <= 1'b0;
		end else if (CE) begin
			sw_clear_q <= 1'b0;
			sw_load_q  <= 1'b0;
			if (apb_acc && !PREADY) begin
				PREADY  <= 1'b1;
				PSLVERR <= ~apb_hit;
				PRDATA  <= (PWRITE || !apb_hit) ? 32'h00000000 : rd_mux;
			end else begin
				PREADY  <= 1'b0;
				PSLVERR <= 1'b0;
			end
			if (apb_wr) begin
				link_en_q  <= PWDATA[`CTRL_LINK_EN];
				sw_clear_q <= PWDATA[`CTRL_CLEAR];
				sw_load_q  <= PWDATA[`CTRL_LOAD];
			end
		end
	end
endmodule // dac_serial_ctrl

/* rtl/pin_sync.v */
`timescale 1ns/1ns
// ==========================================================
// Two-flop synchroniser with edge detection behind it
module pin_sync #(
	parameter W       = 1,
	parameter RST_VAL = 1'b1
) (
	input  wire         clk,   // Core clock
	input  wire         rstn,  // Synchronous reset, active low
	input  wire         ce,    // Clock enable
	input  wire [W-1:0] pins,  // Asynchronous inputs
	output wire [W-1:0] level, // Synchronised level
	output wire [W-1:0] rise,  // One-cycle pulse on rising edge
	output wire [W-1:0] fall   // One-cycle pulse on falling edge
);
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			reg meta_q;
			reg sync_q;
			reg prev_q;
			// First flop feeds only the second one
			always @(posedge clk) begin
				if (!rstn) begin
					meta_q <= RST_VAL;
					sync_q <= RST_VAL;
					prev_q <= RST_VAL;
				end else if (ce) begin
					meta_q <= pins[i];
					sync_q <= meta_q;
					prev_q <= sync_q;
				end
			end
			assign level[i] = sync_q;
			assign rise[i]  = sync_q & ~prev_q;
			assign fall[i]  = ~sync_q & prev_q;
		end
	endgenerate
endmodule // pin_sync

/* rtl/word_store.v */
`timescale 1ns/1ns
// ==========================================================
// Small flop store, one write port and one read port
module word_store #(
	parameter DW = 16,
	parameter AW = 2
) (
	input  wire          clk,     // Core clock
	input  wire          rstn,    // Synchronous reset, active low
	input  wire          ce,      // Clock enable
	input  wire          wr_en,   // Write strobe
	input  wire [AW-1:0] wr_idx,  // Write index
	input  wire [DW-1:0] wr_data, // Write data
	input  wire [AW-1:0] rd_idx,  // Read index
	output wire [DW-1:0] rd_data  // Read data, combinational
);
	reg [DW-1:0] mem_q [0:(1<<AW)-1];
	integer k;
	// Everything powers up at zero
	always @(posedge clk) begin
		if (!rstn) begin
			for (k = 0; k < (1<<AW); k = k + 1) begin
				mem_q[k] <= {DW{1'b0}};
			end
		end else if (ce && wr_en) begin
			mem_q[wr_idx] <= wr_data;
		end
	end
	assign rd_data = mem_q[rd_idx];
endmodule // word_store

/* verification/dac_ctrl_chk.sv */
`timescale 1ns/1ns
// ==========================================================
// Port checks for the serial load controller
module dac_ctrl_chk (
	input wire        CLK,           // Core clock
	input wire        RSTN,          // Reset, active low
	input wire        PSEL,          // APB select
	input wire        PENABLE,       // APB access
	input wire        PWRITE,        // APB direction
	input wire [7:0]  PADDR,         // APB address
	input wire [31:0] PRDATA,        // APB read data
	input wire        PREADY,        // APB ready
	input wire        PSLVERR,       // APB error
	input wire        SER_CLK,       // Serial clock
	input wire        FRAME_SEL_N,   // Frame select
	input wire        LOAD_STROBE_N, // Load strobe
	input wire        CLEAR_N,       // Clear pin
	input wire        CODING_SELECT, // Coding strap
	input wire        SERIAL_OUT,    // Serial out
	input wire [15:0] DAC_A_CODE,    // Code A
	input wire [15:0] DAC_B_CODE,    // Code B
	input wire        OUT_CLAMP      // Clamp
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	logic [3:0] code_age_q; // Cycles since a cause of a code change
	logic [3:0] sout_age_q; // Cycles since a cause of a serial-out change

	// ==========================================================
	// Ages saturate, so a change long after its cause is still caught
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			code_age_q <= 4'h0;
			sout_age_q <= 4'h0;
		end else begin
			code_age_q <= ($rose(FRAME_SEL_N) || $fell(LOAD_STROBE_N) || $fell(CLEAR_N) ||
				$changed(CODING_SELECT) || (PWRITE && PSEL)) ? 4'h0 :
				code_age_q + {3'h0, code_age_q != 4'hf};
			sout_age_q <= ($rose(SER_CLK) || $changed(FRAME_SEL_N) || PSEL) ? 4'h0 :
				sout_age_q + {3'h0, sout_age_q != 4'hf};
		end
	end

	// ==========================================================
	// Assertions
	a_reset_state: assert property ($rose(RSTN) |-> OUT_CLAMP &&
		DAC_A_CODE == 16'h8000 && DAC_B_CODE == 16'h8000) else $error("bad state after reset");
	a_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("ready not one cycle into access");
	a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held too long");
	a_err_addr: assert property (PREADY && PADDR > 8'h18 |-> PSLVERR && PRDATA == 32'h0)
		else $error("unmapped access not refused");
	a_code_cause: assert property ($changed(DAC_A_CODE) || $changed(DAC_B_CODE) |->
		code_age_q < 4'ha) else $error("code changed without a cause");
	a_sout_edge: assert property ($changed(SERIAL_OUT) |-> sout_age_q < 4'h8)
		else $error("serial out changed away from a clock rise");
	a_clear_fall: assert property ($fell(CLEAR_N) |-> ##[2:10] (!OUT_CLAMP &&
		DAC_A_CODE == (CODING_SELECT ? 16'h0000 : 16'h8000))) else $error("clear not applied");
	a_load_fall: assert property ($fell(LOAD_STROBE_N) ##1 !LOAD_STROBE_N [*6] |=>
		!OUT_CLAMP) else $error("load strobe left outputs clamped");
	a_clamp_hold: assert property (OUT_CLAMP && code_age_q == 4'hf |=> OUT_CLAMP)
		else $error("clamp released without an update");
	c_frame: cover property ($rose(FRAME_SEL_N));
	c_clear: cover property ($fell(CLEAR_N));
	c_refuse: cover property (PREADY && PSLVERR);
endmodule // dac_ctrl_chk

bind dac_serial_ctrl dac_ctrl_chk u_chk (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.SER_CLK(SER_CLK), .FRAME_SEL_N(FRAME_SEL_N), .LOAD_STROBE_N(LOAD_STROBE_N),
	.CLEAR_N(CLEAR_N), .CODING_SELECT(CODING_SELECT), .SERIAL_OUT(SERIAL_OUT),
	.DAC_A_CODE(DAC_A_CODE), .DAC_B_CODE(DAC_B_CODE), .OUT_CLAMP(OUT_CLAMP));

/* verification/host_serial_port.sv */
`timescale 1ns/1ns
// ==========================================================
// Host serial port; burst clock that stands still between frames
module host_serial_port (
	output logic        ser_clk,     // Serial clock, low between frames
	output logic        frame_sel_n, // Frame select, active low
	output logic        serial_in,   // Data toward the device
	input  wire         serial_out   // Data back from the device
);
	logic [23:0] rx_word; // Last 24 bits seen on the return line

	// Idle levels at time zero
	initial begin
		ser_clk = 1'h0;
		frame_sel_n = 1'h1;
		serial_in = 1'h0;
		rx_word = 24'h0;
	end

	task automatic open_frame();
		rx_word = 24'h0;
		frame_sel_n = 1'h0;
		#62;
	endtask

	// Data changes on the rise so it is steady well past the fall
	task automatic put_bit(input logic b);
		ser_clk = 1'h1;
		serial_in = b;
		#63;
		rx_word = {rx_word[22:0], serial_out};
		ser_clk = 1'h0;
		#62;
	endtask

	task automatic close_frame();
		frame_sel_n = 1'h1;
		serial_in = ~serial_in; // A released line must not keep its last value
		#300;
	endtask
endmodule // host_serial_port

/* verification/tb_dual_dac_serial_load_control.sv */
`timescale 1ns/1ns
`include "dac_consts.vh"
// ==========================================================
// Self-checking bench for the serial load controller
module tb_dual_dac_serial_load_control;
	typedef struct {logic cs; logic [23:0] w; logic [15:0] a; logic [15:0] b;} row_t;
	logic        CLK, RSTN, PSEL, PENABLE, PWRITE, er;
	logic        LOAD_STROBE_N, CLEAR_N, CODING_SELECT;
	logic [7:0]  PADDR;
	logic [31:0] PWDATA, rd;
	wire  [31:0] PRDATA;
	wire         PREADY, PSLVERR, SER_CLK, FRAME_SEL_N, SERIAL_IN;
	wire         SERIAL_OUT, SERIAL_OUT_EN, OUT_CLAMP;
	wire  [15:0] DAC_A_CODE, DAC_B_CODE;
	int          fail_count = 0;
	int          checks = 0;
	int          cycles = 0;
	logic [47:0] chain = 48'h101111115555; // Two chained frames, first one passes through
	// Frames with the load strobe low: coding, word, expected ladder codes A and B
	row_t rows[7] = '{
		'{1'h0, 24'h101234, 16'h9234, 16'h8000},
		'{1'h0, 24'h11abcd, 16'h9234, 16'h2bcd},
		'{1'h1, 24'h145678, 16'h5678, 16'h5678},
		'{1'h1, 24'h11ffff, 16'h5678, 16'hffff},
		'{1'h0, 24'h140000, 16'h8000, 16'h8000},
		'{1'h0, 24'h107fff, 16'hffff, 16'h8000},
		'{1'h0, 24'h040000, 16'h8000, 16'h8000}};

	dac_serial_ctrl dut (
		.CLK(CLK), .RSTN(RSTN), .CE(1'h1), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.SER_CLK(SER_CLK), .FRAME_SEL_N(FRAME_SEL_N), .SERIAL_IN(SERIAL_IN),
		.LOAD_STROBE_N(LOAD_STROBE_N), .CLEAR_N(CLEAR_N), .CODING_SELECT(CODING_SELECT),
		.SERIAL_OUT(SERIAL_OUT), .SERIAL_OUT_EN(SERIAL_OUT_EN), .DAC_A_CODE(DAC_A_CODE),
		.DAC_B_CODE(DAC_B_CODE), .OUT_CLAMP(OUT_CLAMP));
	host_serial_port host (.ser_clk(SER_CLK), .frame_sel_n(FRAME_SEL_N),
		.serial_in(SERIAL_IN), .serial_out(SERIAL_OUT_EN ? SERIAL_OUT : ~SERIAL_OUT));

	// ==========================================================
	// Clock and hang guard
	initial begin
		CLK = 1'h0;
		forever #5 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cycles++;
		if (cycles > 20000) begin
			fail_count++;
			final_report();
		end
	end

	// ==========================================================
	// Tasks
	task automatic final_report();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_flag(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic dacs(input logic [15:0] a, input logic [15:0] b);
		cmp_word({16'h0, DAC_A_CODE}, {16'h0, a});
		cmp_word({16'h0, DAC_B_CODE}, {16'h0, b});
	endtask
	// Request held until ready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1'h1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'h1;
		do @(posedge CLK); while (PREADY !== 1'h1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
	endtask
	// Sends the low n bits, padding with zeros above bit 23
	task automatic send(input logic [23:0] w, input int n);
		host.open_frame();
		for (int i = n - 1; i >= 0; i--)
			host.put_bit(i < 24 ? w[i] : 1'h0);
		host.close_frame();
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		RSTN = 1'h0;
		PSEL = 1'h0;
		PENABLE = 1'h0;
		PWRITE = 1'h0;
		PADDR = 8'h00;
		PWDATA = 32'h0;
		LOAD_STROBE_N = 1'h1;
		CLEAR_N = 1'h1;
		CODING_SELECT = 1'h0;
		repeat (10) @(posedge CLK);
		RSTN <= 1'h1;
		repeat (4) @(posedge CLK);
		cmp_flag(OUT_CLAMP, 1'h1);
		dacs(16'h8000, 16'h8000);
		cmp_flag(SERIAL_OUT_EN, 1'h1);
		apb(1'h1, `A_CTRL, 32'h1);
		apb(1'h0, `A_CTRL, 32'h0);
		cmp_word(rd, 32'h1);
		apb(1'h0, 8'hfc, 32'h0);
		cmp_flag(er, 1'h1);
		cmp_word(rd, 32'h0);
		LOAD_STROBE_N <= 1'h0;
		repeat (8) @(posedge CLK);
		cmp_flag(OUT_CLAMP, 1'h0);
		dacs(16'h8000, 16'h8000);
		foreach (rows[i]) begin
			@(posedge CLK);
			CODING_SELECT <= rows[i].cs;
			send(rows[i].w, 24);
			dacs(rows[i].a, rows[i].b);
		end
		// Held strobe defers both outputs to its fall
		LOAD_STROBE_N <= 1'h1;
		send(24'h100001, 24);
		send(24'h110002, 24);
		dacs(16'h8000, 16'h8000);
		@(posedge CLK);
		LOAD_STROBE_N <= 1'h0;
		repeat (8) @(posedge CLK);
		dacs(16'h8001, 16'h8002);
		LOAD_STROBE_N <= 1'h1;
		send(24'h100003, 24);
		dacs(16'h8001, 16'h8002);
		send(24'h050000, 24);
		dacs(16'h8003, 16'h8002);
		// Short and long frames with the strobe low must change nothing
		LOAD_STROBE_N <= 1'h0;
		send(24'h10aaaa, 23);
		send(24'h10aaaa, 25);
		dacs(16'h8003, 16'h8002);
		apb(1'h0, `A_BAD, 32'h0);
		cmp_word(rd, 32'h2);
		host.open_frame();
		for (int i = 47; i >= 0; i--)
			host.put_bit(chain[i]);
		host.close_frame();
		cmp_word({8'h0, host.rx_word}, 32'h101111);
		dacs(16'h8003, 16'hd555);
		send(24'h20ffff, 24);
		send(24'ha00000, 24);
		send(24'h000000, 24);
		cmp_word({8'h0, host.rx_word}, 32'h3f);
		send(24'h010001, 24);
		cmp_flag(SERIAL_OUT_EN, 1'h0);
		send(24'h010000, 24);
		cmp_flag(SERIAL_OUT_EN, 1'h1);
		@(posedge CLK);
		CODING_SELECT <= 1'h1;
		send(24'h141234, 24);
		dacs(16'h1234, 16'h1234);
		CLEAR_N <= 1'h0;
		repeat (6) @(posedge CLK);
		CLEAR_N <= 1'h1;
		repeat (20) @(posedge CLK);
		dacs(16'h0000, 16'h0000);
		apb(1'h1, `A_CTRL, 32'h5);
		repeat (4) @(posedge CLK);
		dacs(16'h1234, 16'h1234);
		RSTN <= 1'h0;
		CLEAR_N <= 1'h0;
		repeat (10) @(posedge CLK);
		RSTN <= 1'h1;
		repeat (10) @(posedge CLK);
		cmp_flag(OUT_CLAMP, 1'h0);
		dacs(16'h0000, 16'h0000);
		final_report();
	end
endmodule // tb_dual_dac_serial_load_control
